// ### include/pmw_defines.vh
`ifndef PMW_DEFINES_VH
`define PMW_DEFINES_VH

// register byte offsets
`define PMW_OFF_CTRL    12'h000
`define PMW_OFF_FUNC_EN 12'h004
`define PMW_OFF_PCR3    12'h008
`define PMW_OFF_PULL_UP 12'h00c
`define PMW_OFF_PULL_DN 12'h010
`define PMW_OFF_STATUS  12'h014
`define PMW_OFF_IRQ_MSK 12'h018
`define PMW_OFF_STATE   12'h01c

// power modes
`define PMW_MODE_RUN    3'h0
`define PMW_MODE_SLEEP  3'h1
`define PMW_MODE_LPRUN  3'h2
`define PMW_MODE_LPSLP  3'h3
`define PMW_MODE_STOP   3'h4
`define PMW_MODE_STBY   3'h5
`define PMW_MODE_SHDN   3'h6
`define PMW_MODE_VBAT   3'h7

// control register fields
`define PMW_CTRL_MODE_LO  0
`define PMW_CTRL_MODE_HI  2
`define PMW_CTRL_FLASH_PD 3
`define PMW_CTRL_RANGE1   4
`define PMW_CTRL_CHARGE   5
`define PMW_CTRL_RESET    32'h0000_0010

// third power control register fields
`define PMW_PCR3_RETAIN   0
`define PMW_PCR3_WKP_LO   1
`define PMW_PCR3_WKP_HI   5

// function enable bit positions
`define PMW_FN_SERIAL 0
`define PMW_FN_I2C    1
`define PMW_FN_LPTIM  2
`define PMW_FN_COMP   3
`define PMW_FN_RANDOM 4
`define PMW_FN_DMA    5
`define PMW_FN_W      6
`define PMW_FN_RESET  6'h00

// status event bit positions
`define PMW_EV_SERIAL 0
`define PMW_EV_I2C    1
`define PMW_EV_PIN    2
`define PMW_EV_VBAT   3
`define PMW_EV_TAMPER 4
`define PMW_EV_W      5

`define PMW_WKP_N     5
`define PMW_TAMP_N    3
`define PMW_NPERIPH   4
`define PMW_IO_N      16

// availability masks per mode, one bit per function
`define PMW_AV_RUN  6'h3f
`define PMW_AV_LP   6'h2f
`define PMW_AV_STOP 6'h0f
`define PMW_AV_NONE 6'h00

// multispeed oscillator range code for 4 MHz
`define PMW_MSI_4MEG 4'h6

`endif

// ### rtl/pmw_gating.v
`timescale 1ns/1ns
`include "pmw_defines.vh"

module pmw_gating (
  input wire I_CLK_SYS,
  input wire I_NRST,
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [11:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output wire [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  input wire I_VDD_OK,
  input wire I_RST_INTERNAL,
  input wire [3:0] I_OSC_REQ,
  input wire I_SERIAL_EVT,
  input wire I_I2C_ADDR_MATCH,
  input wire [4:0] I_WKP_PIN,
  input wire [2:0] I_TAMPER,
  input wire I_EXT_IRQ,
  input wire I_RTC_ALARM,
  input wire I_IO_WAKE_OTHER,
  output reg [2:0] O_MODE,
  output reg [5:0] O_FUNC_CLK_EN,
  output reg O_FLASH_PD,
  output reg O_RAM2_RETAIN,
  output reg O_INTERNAL_SIXTEEN_MEG_OSC_ON,
  output reg [3:0] O_INTERNAL_SIXTEEN_MEG_OSC_ROUTE,
  output reg O_WAKEUP,
  output reg O_TAMPER_EVT,
  output reg O_CHARGE_EN,
  output reg O_RANDOM_EN,
  output reg [3:0] O_MSI_RANGE,
  output reg O_IO_ANALOG,
  output reg O_SCHMITT_EN,
  output reg [15:0] O_IO_PULL_UP,
  output reg [15:0] O_IO_PULL_DN,
  output reg O_NRST_PULLUP,
  output wire O_IRQ
);

//////////////////////////////////////////////////////////////////////////////
// register file
reg [31:0] ctrl;
reg [5:0] func_en;
reg [5:0] pcr3;
reg [15:0] pull_up;
reg [15:0] pull_dn;
reg [4:0] status;
reg [4:0] irq_msk;
reg io_configured;
reg [31:0] rdata;
reg [31:0] next_rdata;
reg [2:0] req_mode;
reg [4:0] ev;
reg [4:0] wkp_prev;
wire acc = I_PSEL & I_PENABLE;
wire rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;
wire wr = acc & I_PWRITE;
wire rd = acc & ~I_PWRITE;
wire [2:0] wr_mode = I_PWDATA[`PMW_CTRL_MODE_HI:`PMW_CTRL_MODE_LO];
wire bat = ~I_VDD_OK;
wire hit = (I_PADDR == `PMW_OFF_CTRL) | (I_PADDR == `PMW_OFF_FUNC_EN) |
  (I_PADDR == `PMW_OFF_PCR3) | (I_PADDR == `PMW_OFF_PULL_UP) |
  (I_PADDR == `PMW_OFF_PULL_DN) | (I_PADDR == `PMW_OFF_STATUS) |
  (I_PADDR == `PMW_OFF_IRQ_MSK) | (I_PADDR == `PMW_OFF_STATE);

// single-cycle access phase, zero wait states
assign O_PREADY = 1'b1;
assign O_PSLVERR = acc & ~hit;
assign O_PRDATA = rdata;
assign O_IRQ = |(status & irq_msk);

always @* begin
  next_rdata = 32'h0000_0000;
  case (I_PADDR)
    `PMW_OFF_CTRL: next_rdata = ctrl;
    `PMW_OFF_FUNC_EN: next_rdata = {26'h0, func_en};
    `PMW_OFF_PCR3: next_rdata = {26'h0, pcr3};
    `PMW_OFF_PULL_UP: next_rdata = {16'h0, pull_up};
    `PMW_OFF_PULL_DN: next_rdata = {16'h0, pull_dn};
    `PMW_OFF_STATUS: next_rdata = {27'h0, status};
    `PMW_OFF_IRQ_MSK: next_rdata = {27'h0, irq_msk};
    `PMW_OFF_STATE: next_rdata = {25'h0, O_INTERNAL_SIXTEEN_MEG_OSC_ON, bat, O_MODE};
    default: next_rdata = 32'h0000_0000;
  endcase
end

//////////////////////////////////////////////////////////////////////////////
// wakeup events per mode
always @* begin
  ev = 5'h00;
  if (O_MODE == `PMW_MODE_STOP) begin
    ev[`PMW_EV_SERIAL] = I_SERIAL_EVT & func_en[`PMW_FN_SERIAL];
    ev[`PMW_EV_I2C] = I_I2C_ADDR_MATCH & func_en[`PMW_FN_I2C];
  end
  // rising edge on an enabled dedicated pin; no other io is looked at
  if (O_MODE == `PMW_MODE_STBY || O_MODE == `PMW_MODE_SHDN)
    ev[`PMW_EV_PIN] = |(I_WKP_PIN & ~wkp_prev &
      pcr3[`PMW_PCR3_WKP_HI:`PMW_PCR3_WKP_LO]);
  ev[`PMW_EV_VBAT] = bat & (O_MODE != `PMW_MODE_VBAT);
  ev[`PMW_EV_TAMPER] = |I_TAMPER;
end

always @(posedge I_CLK_SYS or negedge I_NRST) begin
  if (!I_NRST) begin
    ctrl <= `PMW_CTRL_RESET;
    func_en <= `PMW_FN_RESET;
    pcr3 <= 6'h00;
    pull_up <= 16'h0000;
    pull_dn <= 16'h0000;
    status <= 5'h00;
    irq_msk <= 5'h00;
    rdata <= 32'h0000_0000;
    wkp_prev <= 5'h00;
    io_configured <= 1'b0;
  end else begin
    wkp_prev <= I_WKP_PIN;
    // read data is loaded in the setup cycle so it stands at the access edge
    if (rd_setup)
      rdata <= next_rdata;
    // only the bits that were reported are cleared; a new event still sets
    if (rd && I_PADDR == `PMW_OFF_STATUS)
      status <= (status & ~rdata[4:0]) | ev;
    else
      status <= status | ev;
    if (wr) begin
      case (I_PADDR)
        `PMW_OFF_CTRL: ctrl <= {26'h0, I_PWDATA[5:0]};
        `PMW_OFF_FUNC_EN: func_en <= I_PWDATA[5:0];
        `PMW_OFF_PCR3: pcr3 <= I_PWDATA[5:0];
        `PMW_OFF_PULL_UP: begin
          pull_up <= I_PWDATA[15:0];
          io_configured <= 1'b1;
        end
        `PMW_OFF_PULL_DN: begin
          pull_dn <= I_PWDATA[15:0];
          io_configured <= 1'b1;
        end
        `PMW_OFF_IRQ_MSK: irq_msk <= I_PWDATA[4:0];
        default: ;
      endcase
    end
    // a wakeup out of shutdown discards its pull selection
    if (O_MODE == `PMW_MODE_SHDN && O_WAKEUP) begin
      pull_up <= 16'h0000;
      pull_dn <= 16'h0000;
      io_configured <= 1'b0;
    end
  end
end

//////////////////////////////////////////////////////////////////////////////
// mode sequencing
always @* begin
  req_mode = O_MODE;
  if (wr && I_PADDR == `PMW_OFF_CTRL && wr_mode != `PMW_MODE_VBAT)
    req_mode = wr_mode;
  // battery domain is left only when main supply returns
  if (bat)
    req_mode = `PMW_MODE_VBAT;
  else if (O_MODE == `PMW_MODE_VBAT)
    req_mode = `PMW_MODE_RUN;
  else if (O_WAKEUP)
    req_mode = `PMW_MODE_RUN;
end

always @(posedge I_CLK_SYS or negedge I_NRST) begin
  if (!I_NRST) begin
    O_MODE <= `PMW_MODE_RUN;
    O_WAKEUP <= 1'b0;
    O_MSI_RANGE <= `PMW_MSI_4MEG;
    O_NRST_PULLUP <= 1'b1;
  end else begin
    O_MODE <= req_mode;
    // ext irq and rtc alarm never wake from battery operation
    case (O_MODE)
      `PMW_MODE_STOP: O_WAKEUP <= |(ev[1:0]) | I_EXT_IRQ | I_RTC_ALARM;
      `PMW_MODE_STBY: O_WAKEUP <= ev[`PMW_EV_PIN] | I_RTC_ALARM;
      `PMW_MODE_SHDN: O_WAKEUP <= ev[`PMW_EV_PIN] | I_RTC_ALARM;
      `PMW_MODE_VBAT: O_WAKEUP <= 1'b0;
      default: O_WAKEUP <= 1'b0;
    endcase
    if (O_MODE == `PMW_MODE_SHDN && O_WAKEUP)
      O_MSI_RANGE <= `PMW_MSI_4MEG;
    // pull-up released while an internal source holds reset
    O_NRST_PULLUP <= ~I_RST_INTERNAL;
  end
end

//////////////////////////////////////////////////////////////////////////////
// gating outputs
reg [5:0] avail;
always @* begin
  case (O_MODE)
    `PMW_MODE_RUN: avail = `PMW_AV_RUN;
    `PMW_MODE_SLEEP: avail = `PMW_AV_RUN;
    `PMW_MODE_LPRUN: avail = `PMW_AV_LP;
    `PMW_MODE_LPSLP: avail = `PMW_AV_LP;
    `PMW_MODE_STOP: avail = `PMW_AV_STOP;
    default: avail = `PMW_AV_NONE;
  endcase
end

wire stop = (O_MODE == `PMW_MODE_STOP);
wire range1 = ctrl[`PMW_CTRL_RANGE1];
wire run_or_sleep = (O_MODE == `PMW_MODE_RUN) |
  (O_MODE == `PMW_MODE_SLEEP);

always @(posedge I_CLK_SYS or negedge I_NRST) begin
  if (!I_NRST) begin
    O_FUNC_CLK_EN <= `PMW_FN_RESET;
    O_FLASH_PD <= 1'b0;
    O_RAM2_RETAIN <= 1'b0;
    O_INTERNAL_SIXTEEN_MEG_OSC_ON <= 1'b0;
    O_INTERNAL_SIXTEEN_MEG_OSC_ROUTE <= 4'h0;
    O_TAMPER_EVT <= 1'b0;
    O_CHARGE_EN <= 1'b0;
    O_RANDOM_EN <= 1'b0;
    O_IO_ANALOG <= 1'b1;
    O_SCHMITT_EN <= 1'b0;
    O_IO_PULL_UP <= 16'h0000;
    O_IO_PULL_DN <= 16'h0000;
  end else begin
    O_FUNC_CLK_EN <= avail & func_en;
    O_FLASH_PD <= ctrl[`PMW_CTRL_FLASH_PD] & ~bat;
    // contents survive standby only with retention set
    O_RAM2_RETAIN <= pcr3[`PMW_PCR3_RETAIN] &
      (O_MODE == `PMW_MODE_STBY);
    // in stop mode the oscillator follows live requests, so it drops with the last one; off in every other mode
    O_INTERNAL_SIXTEEN_MEG_OSC_ON <= stop & (|I_OSC_REQ);
    O_INTERNAL_SIXTEEN_MEG_OSC_ROUTE <= stop ? I_OSC_REQ : 4'h0;
    O_TAMPER_EVT <= |I_TAMPER;
    O_CHARGE_EN <= ctrl[`PMW_CTRL_CHARGE] & I_VDD_OK;
    O_RANDOM_EN <= func_en[`PMW_FN_RANDOM] & run_or_sleep & range1;
    // ios stay analog until software gives them a pull setup
    O_IO_ANALOG <= ~io_configured;
    O_SCHMITT_EN <= io_configured & ~bat;
    O_IO_PULL_UP <= pull_up;
    O_IO_PULL_DN <= pull_dn & ~pull_up;
  end
end

endmodule // pmw_gating

// ### test/pmw_periph_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module pmw_periph_model (
  input wire i_clk,
  input wire [3:0] i_want,
  input wire [3:0] i_route,
  output reg [3:0] o_osc_req
);
  initial o_osc_req = 4'h0;
  // a peripheral keeps asking until its clock has arrived at least once
  always @(posedge i_clk) begin
    o_osc_req <= i_want | (o_osc_req & ~i_route);
  end
endmodule // pmw_periph_model

// ### test/pmw_monitor.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module pmw_monitor (
  input wire I_CLK_SYS,
  input wire I_NRST,
  input wire I_VDD_OK,
  input wire I_RST_INTERNAL,
  input wire [3:0] I_OSC_REQ,
  input wire [4:0] I_WKP_PIN,
  input wire [2:0] O_MODE,
  input wire O_INTERNAL_SIXTEEN_MEG_OSC_ON,
  input wire [3:0] O_INTERNAL_SIXTEEN_MEG_OSC_ROUTE,
  input wire O_WAKEUP,
  input wire O_IO_ANALOG,
  input wire O_SCHMITT_EN,
  input wire O_NRST_PULLUP,
  input wire O_CHARGE_EN,
  input wire O_RANDOM_EN,
  input wire [15:0] O_IO_PULL_UP,
  input wire [3:0] O_MSI_RANGE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  sequence s_shdn_exit;
    O_MODE == 3'h6 ##1 O_MODE == 3'h0;
  endsequence
  a_osc_on_req: assert property ((O_MODE == 3'h4 && |I_OSC_REQ) |=> O_INTERNAL_SIXTEEN_MEG_OSC_ON)
    else $error("oscillator not started");
  a_osc_auto_off: assert property ((O_MODE == 3'h4 && I_OSC_REQ == 4'h0) |=> !O_INTERNAL_SIXTEEN_MEG_OSC_ON)
    else $error("oscillator left running");
  a_route_only_req: assert property ((O_INTERNAL_SIXTEEN_MEG_OSC_ROUTE & ~$past(I_OSC_REQ)) == 4'h0)
    else $error("oscillator routed to idle peripheral");
  a_schmitt_analog: assert property (O_IO_ANALOG |-> !O_SCHMITT_EN)
    else $error("schmitt on in analog state");
  a_pullup_internal: assert property (I_RST_INTERNAL |=> !O_NRST_PULLUP)
    else $error("reset pull-up kept on");
  a_battery_entry: assert property (!I_VDD_OK |-> ##[1:2] O_MODE == 3'h7)
    else $error("battery domain not entered");
  a_battery_hold: assert property ((O_MODE == 3'h7 && !I_VDD_OK) |=> O_MODE == 3'h7)
    else $error("battery domain left");
  a_charge_vdd: assert property (!I_VDD_OK |=> !O_CHARGE_EN)
    else $error("charger on without supply");
  a_random_mode: assert property ((O_MODE > 3'h1) [*2] |-> !O_RANDOM_EN)
    else $error("random source on in low-power mode");
  a_other_no_wake: assert property ((O_MODE inside {3'h5, 3'h6} && $stable(I_WKP_PIN)) |=> !O_WAKEUP)
    else $error("wakeup without pin edge");
  a_shdn_exit_pull: assert property (s_shdn_exit |-> ##[0:1] O_IO_PULL_UP == 16'h0)
    else $error("pulls kept after shutdown");
  a_shdn_exit_osc: assert property (s_shdn_exit |-> ##[0:1] O_MSI_RANGE == 4'h6)
    else $error("wrong restart oscillator");
endmodule // pmw_monitor
bind pmw_gating pmw_monitor pmw_monitor_inst (.I_CLK_SYS(I_CLK_SYS),
  .I_NRST(I_NRST), .I_VDD_OK(I_VDD_OK), .I_RST_INTERNAL(I_RST_INTERNAL),
  .I_OSC_REQ(I_OSC_REQ), .I_WKP_PIN(I_WKP_PIN), .O_MODE(O_MODE),
  .O_INTERNAL_SIXTEEN_MEG_OSC_ON(O_INTERNAL_SIXTEEN_MEG_OSC_ON), .O_INTERNAL_SIXTEEN_MEG_OSC_ROUTE(O_INTERNAL_SIXTEEN_MEG_OSC_ROUTE),
  .O_WAKEUP(O_WAKEUP), .O_IO_ANALOG(O_IO_ANALOG),
  .O_SCHMITT_EN(O_SCHMITT_EN), .O_NRST_PULLUP(O_NRST_PULLUP),
  .O_CHARGE_EN(O_CHARGE_EN), .O_RANDOM_EN(O_RANDOM_EN),
  .O_IO_PULL_UP(O_IO_PULL_UP), .O_MSI_RANGE(O_MSI_RANGE));

// ### test/pmw_gating_tb.sv
`timescale 1ns/1ns
`include "pmw_defines.vh"
`define CHK(n,e,s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
////////////////////////////////////////////////////////////////////////////
module pmw_gating_tb;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, vdd = 1, rint = 0;
  logic sev = 0, i2c = 0, eirq = 0, rtc = 0, oth = 0, rw;
  logic [11:0] pa = 0, ra;
  logic [31:0] pwd = 0, q, rd, re, prd;
  logic [4:0] wkp = 0;
  logic [2:0] tmp = 0, mode;
  logic [3:0] want = 0, req, hrt, multispeed_internal_osc;
  logic [5:0] fce;
  logic [15:0] pu, pd;
  logic wk, slv, err;
  logic rdy, fpd, ram2, hon, tev, chg, rnd, ana, sch, npu, irq;
  logic [76:0] rows [0:8];
  int failures = 0, compares = 0;
  always #25 clk = ~clk;
  pmw_periph_model pmw_periph_model_inst (.i_clk(clk), .i_want(want),
    .i_route(hrt), .o_osc_req(req));
  pmw_gating pmw_gating_inst (.I_CLK_SYS(clk), .I_NRST(nrst), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa), .I_PWDATA(pwd),
    .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(slv), .I_VDD_OK(vdd),
    .I_RST_INTERNAL(rint), .I_OSC_REQ(req), .I_SERIAL_EVT(sev),
    .I_I2C_ADDR_MATCH(i2c), .I_WKP_PIN(wkp), .I_TAMPER(tmp), .I_EXT_IRQ(eirq),
    .I_RTC_ALARM(rtc), .I_IO_WAKE_OTHER(oth), .O_MODE(mode),
    .O_FUNC_CLK_EN(fce), .O_FLASH_PD(fpd), .O_RAM2_RETAIN(ram2),
    .O_INTERNAL_SIXTEEN_MEG_OSC_ON(hon), .O_INTERNAL_SIXTEEN_MEG_OSC_ROUTE(hrt), .O_WAKEUP(wk), .O_TAMPER_EVT(tev),
    .O_CHARGE_EN(chg), .O_RANDOM_EN(rnd), .O_MSI_RANGE(multispeed_internal_osc),
    .O_IO_ANALOG(ana), .O_SCHMITT_EN(sch), .O_IO_PULL_UP(pu),
    .O_IO_PULL_DN(pd), .O_NRST_PULLUP(npu), .O_IRQ(irq));
  task close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // read data and error are taken at the edge that completes the access
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    q = prd;
    err = slv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // whole run is about 130 cycles; some thirty times that is a hang
  initial begin
    #200000;
    failures++;
    close_out;
  end
  initial begin
    rows = '{{1'b0, `PMW_OFF_CTRL, 32'h0, 32'h10},
      {1'b0, `PMW_OFF_FUNC_EN, 32'h0, 32'h0}, {1'b0, `PMW_OFF_PCR3, 32'h0, 32'h0},
      {1'b1, `PMW_OFF_FUNC_EN, 32'h3f, 32'h0},
      {1'b0, `PMW_OFF_FUNC_EN, 32'h0, 32'h3f},
      {1'b1, `PMW_OFF_PCR3, 32'h3f, 32'h0}, {1'b0, `PMW_OFF_PCR3, 32'h0, 32'h3f},
      {1'b0, 12'h020, 32'h0, 32'h0}, {1'b1, `PMW_OFF_IRQ_MSK, 32'h0, 32'h0}};
    step(5);
    `CHK("analog", 1'b1, ana)
    `CHK("schmitt", 1'b0, sch)
    `CHK("flash_pd", 1'b0, fpd)
    `CHK("clk_en", 6'h00, fce)
    step(5);
    @(posedge clk) nrst <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      {rw, ra, rd, re} = rows[i];
      apb(rw, ra, rd);
      if (!rw) `CHK("reg", re, q)
      `CHK("slverr", (ra > `PMW_OFF_STATE), err)
    end
    step(2);
    `CHK("clk_en", 6'h3f, fce)
    `CHK("retain", 1'b0, ram2)
    `CHK("random", 1'b1, rnd)
    apb(1'b1, `PMW_OFF_CTRL, 32'h30);
    step(2);
    `CHK("charge", 1'b1, chg)
    apb(1'b1, `PMW_OFF_CTRL, 32'h14);
    step(2);
    `CHK("clk_en", 6'h0f, fce)
    `CHK("random", 1'b0, rnd)
    @(posedge clk) want <= 4'h4;
    step(4);
    `CHK("osc_on", 1'b1, hon)
    `CHK("route", 4'h4, hrt)
    @(posedge clk) want <= 4'h0;
    step(4);
    `CHK("osc_on", 1'b0, hon)
    @(posedge clk) sev <= 1'b1;
    @(posedge clk) sev <= 1'b0;
    step(2);
    `CHK("mode", 3'h0, mode)
    `CHK("irq", 1'b0, irq)
    apb(1'b1, `PMW_OFF_IRQ_MSK, 32'h1f);
    step(1);
    `CHK("irq", 1'b1, irq)
    apb(1'b0, `PMW_OFF_STATUS, 32'h0);
    `CHK("status", 32'h1, q)
    step(1);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, `PMW_OFF_CTRL, 32'h14);
    step(2);
    @(posedge clk) i2c <= 1'b1;
    @(posedge clk) i2c <= 1'b0;
    step(2);
    `CHK("mode", 3'h0, mode)
    apb(1'b1, `PMW_OFF_PULL_UP, 32'hff);
    step(2);
    `CHK("pull_up", 16'h00ff, pu)
    apb(1'b1, `PMW_OFF_PULL_DN, 32'hff00);
    step(2);
    `CHK("pull_dn", 16'hff00, pd)
    apb(1'b1, `PMW_OFF_CTRL, 32'h15);
    step(2);
    `CHK("retain", 1'b1, ram2)
    @(posedge clk) wkp <= 5'h01;
    step(1);
    `CHK("wake", 1'b1, wk)
    step(2);
    `CHK("mode", 3'h0, mode)
    @(posedge clk) wkp <= 5'h00;
    apb(1'b1, `PMW_OFF_CTRL, 32'h16);
    step(2);
    @(posedge clk) oth <= 1'b1;
    step(3);
    `CHK("mode", 3'h6, mode)
    @(posedge clk) wkp <= 5'h10;
    step(3);
    `CHK("mode", 3'h0, mode)
    `CHK("pull_up", 16'h0, pu)
    `CHK("msi", 4'h6, multispeed_internal_osc)
    @(posedge clk) vdd <= 1'b0;
    step(3);
    `CHK("mode", 3'h7, mode)
    `CHK("charge", 1'b0, chg)
    @(posedge clk) eirq <= 1'b1;
    rtc <= 1'b1;
    step(3);
    `CHK("mode", 3'h7, mode)
    @(posedge clk) tmp <= 3'h4;
    step(1);
    `CHK("tamper", 1'b1, tev)
    @(posedge clk) vdd <= 1'b1;
    nrst <= 1'b0;
    step(2);
    @(posedge clk) nrst <= 1'b1;
    rint <= 1'b1;
    step(2);
    `CHK("nrst_pullup", 1'b0, npu)
    close_out;
  end
endmodule // pmw_gating_tb
